// [dv/slm_rx_model.sv]
// Receiver model that checks one lane of pseudo-random test pattern.
`timescale 1ns/100ps
module slm_rx_model
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        clr_i,
  input  wire logic        valid_i,
  input  wire logic [7:0]  lane_i,
  input  wire logic [4:0]  tap_a_i,
  input  wire logic [4:0]  tap_b_i,
  output logic      [15:0] err_o,
  output logic      [15:0] good_o
);
  logic [30:0] hist;
  logic [5:0]  seen;

  // The start phase is unknown, so history is filled from the line before any bit is judged.
  always @(posedge sys_clk_i or negedge rst_b_i)
  begin : rx_check
    int i;
    if (!rst_b_i || clr_i)
    begin
      hist = 31'h0;
      seen = 6'h0;
      err_o = 16'h0;
      good_o = 16'h0;
    end
    else if (valid_i)
    begin
      for (i = 7; i >= 0; i--)
      begin
        if (seen >= {1'b0, tap_b_i})
        begin
          if ((hist[tap_a_i - 1] ^ hist[tap_b_i - 1]) === lane_i[i])
            good_o++;
          else
            err_o++;
        end
        hist = {hist[29:0], lane_i[i]};
        if (seen < 6'd32)
          seen++;
      end
    end
  end
endmodule // slm_rx_model

// [dv/tb_serial_lane_map_test_power.sv]
// Self-checking bench for the lane mapper: registers, lane maps, power-down and test patterns.
`timescale 1ns/100ps
module tb_serial_lane_map_test_power;
  logic        sys_clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wr_data_i = 32'h0;
  logic        wr_en_i = 1'b0;
  logic        rd_en_i = 1'b0;
  logic        power_down_pin_i = 1'b0;
  logic        smp_valid_i = 1'b0;
  logic [11:0] smp_a_i = 12'h0, smp_b_i = 12'h0, smp_c_i = 12'h0, smp_d_i = 12'h0;
  logic [31:0] rd_data_o;
  logic [63:0] lane_data_o;
  logic [7:0]  lane_valid_o, lane_drv_en_o;
  logic        link_bypass_o, sync_hdr_fec_o;
  logic        rx_clr = 1'b0;
  logic [4:0]  tap_a = 5'h06, tap_b = 5'h07;
  logic [15:0] rx_err, rx_good;
  logic [31:0] rnd = 32'hde21;
  logic [1:0]  rr = 2'h0;
  logic [1:0]  cfg_pair = 2'h3;
  logic        chk_lanes = 1'b0;
  logic        q [8][$];
  int          cfg_map, cfg_four, cfg_alt, n_fail, samples_checked, cyc;

  slm_top DUT (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .power_down_pin_i(power_down_pin_i), .smp_valid_i(smp_valid_i), .smp_a_i(smp_a_i),
    .smp_b_i(smp_b_i), .smp_c_i(smp_c_i), .smp_d_i(smp_d_i), .lane_data_o(lane_data_o),
    .lane_valid_o(lane_valid_o), .lane_drv_en_o(lane_drv_en_o),
    .link_bypass_o(link_bypass_o), .sync_hdr_fec_o(sync_hdr_fec_o));

  slm_rx_model rx (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .clr_i(rx_clr),
    .valid_i(lane_valid_o[0]), .lane_i(lane_data_o[7:0]), .tap_a_i(tap_a), .tap_b_i(tap_b),
    .err_o(rx_err), .good_o(rx_good));

  always #25 sys_clk_i = ~sys_clk_i;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // Physical lane of a channel's sample under the current map, or -1 when it is dropped.
  function automatic int lane_of(input int ch);
    int l;
    l = (cfg_map == 1) ? 2 * ch + rr[0] : ((ch < 2) ? 4 * ch + rr : -1);
    if (l < 0 || (cfg_four != 0 && l > 3))
      return -1;
    if (!cfg_pair[(cfg_map == 1 && l > 3) ? 1 : 0])
      return -1;
    return (cfg_four != 0 && cfg_alt != 0) ? l + 4 : l;
  endfunction

  // Driver enables a running control word should give: quad pairs gate halves, dual needs pair 0.
  function automatic logic [7:0] drv_exp(input logic [31:0] c);
    logic [7:0] m;
    m = (c[1:0] == 2'h1) ? {{4{c[6]}}, {4{c[5]}}} : {8{c[5]}};
    if (c[2])
      m = m & 8'h0f;
    return (c[2] && c[3]) ? {m[3:0], 4'h0} : m;
  endfunction

  task automatic chk(input string w, input logic [63:0] e, input logic [63:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    wr_en_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge sys_clk_i);
    wr_en_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk_i);
    rd_en_i <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_en_i <= 1'b0;
    #1 d = rd_data_o;
  endtask

  task automatic wait_drv();
    int k;
    for (k = 0; k < 20 && lane_drv_en_o === 8'h00; k++)
      @(posedge sys_clk_i);
    #1;
  endtask

  // Power-cycle through the pin so that packers and the round-robin counter start clean.
  task automatic restart(input logic [31:0] c);
    logic [31:0] d;
    chk_lanes = 1'b0;
    @(posedge sys_clk_i);
    power_down_pin_i <= 1'b1;
    repeat (8) @(posedge sys_clk_i);
    chk("drivers off", 64'h0, lane_drv_en_o);
    rd(8'h04, d);
    chk("status down", 32'h00000002, d);
    wr(8'h00, c);
    power_down_pin_i <= 1'b0;
    wait_drv();
    chk("drivers on", drv_exp(c), lane_drv_en_o);
    rd(8'h00, d);
    chk("ctrl kept", c, d);
    repeat (4) @(posedge sys_clk_i);
    foreach (q[p])
      q[p].delete();
    {cfg_map, cfg_four, cfg_alt, cfg_pair, rr} = {32'(c[1:0]), 32'(c[2]), 32'(c[3]), c[6:5], 2'h0};
    chk_lanes = 1'b1;
  endtask

  task automatic stream(input int n);
    logic [47:0] s;
    int c, l, i;
    repeat (n)
    begin
      @(posedge sys_clk_i);
      rnd = xs(rnd);
      s[31:0] = rnd;
      rnd = xs(rnd);
      s[47:32] = rnd[15:0];
      smp_valid_i <= rnd[31] | rnd[30];
      {smp_d_i, smp_c_i, smp_b_i, smp_a_i} <= s;
      if (rnd[31] | rnd[30])
      begin
        for (c = 0; c < 4; c++)
        begin
          l = lane_of(c);
          for (i = 11; l >= 0 && i >= ((cfg_map == 0) ? 2 : 0); i--)
            q[l].push_back(s[12 * c + i]);
        end
        rr++;
      end
    end
    @(posedge sys_clk_i);
    smp_valid_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    foreach (q[p])
      chk("lane leftover", 1, q[p].size() < 8);
  endtask

  always @(posedge sys_clk_i)
  begin : lane_mon
    logic [7:0] e;
    int p, k;
    for (p = 0; p < 8; p++)
      if (chk_lanes && lane_valid_o[p])
      begin
        for (k = 0; k < 8; k++)
          e = {e[6:0], (q[p].size() > 0) ? q[p].pop_front() : 1'bx};
        chk("lane octet", e, lane_data_o[8 * p +: 8]);
      end
  end

  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      results();
    end
  end

  initial
  begin : main
    logic [31:0] d;
    logic [31:0] sig [8];
    logic [31:0] tbl [6];
    int ta [5];
    int tb [5];
    int m, p, r;
    // Pair code 00 is never written; full shutdown uses the pin or the mode field.
    tbl = '{32'h60, 32'h61, 32'h62, 32'h21, 32'h6d, 32'h69};
    ta = '{6, 5, 14, 18, 28};
    tb = '{7, 9, 15, 23, 31};
    repeat (12) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    wait_drv();
    rd(8'h00, d);
    chk("ctrl reset", 32'h60, d);
    rd(8'h04, d);
    chk("status", 32'h0000ff01, d);
    rd(8'h08, d);
    chk("unmapped", 32'h0, d);
    wr(8'h00, 32'h770);
    rd(8'h00, d);
    chk("bad test code", 32'h70, d);
    chk("fec", 1, sync_hdr_fec_o);
    wr(8'h00, 32'h60);
    rd(8'h00, d);
    chk("crc", 0, sync_hdr_fec_o);
    $display("test registers done");
    for (m = 0; m < 6; m++)
    begin
      restart(tbl[m]);
      stream(300);
      $display("test map %h done", tbl[m]);
    end
    chk_lanes = 1'b0;
    for (m = 1; m <= 6; m++)
    begin
      if (m < 6)
        {tap_a, tap_b} = {5'(ta[m - 1]), 5'(tb[m - 1])};
      wr(8'h00, {21'h0, 3'(m), 8'h60});
      repeat (5) @(posedge sys_clk_i);
      rx_clr <= 1'b1;
      @(posedge sys_clk_i);
      rx_clr <= 1'b0;
      repeat (150) @(posedge sys_clk_i);
      #1;
      chk("bypass", 1, link_bypass_o);
      chk("test drivers", 8'hff, lane_drv_en_o);
      if (m < 6)
      begin
        chk("prbs errors", 0, rx_err);
        chk("prbs bits", 1, rx_good > 16'd1000);
      end
      for (r = 0; r < 4; r++)
      begin
        for (p = 0; p < 8; p++)
          sig[p] = {sig[p][23:0], lane_data_o[8 * p +: 8]};
        if (m == 6)
          chk("clock level", 1, lane_data_o === {64{sig[0][0]}});
        if (m == 6 && r > 0)
          chk("clock toggle", {8{~sig[0][15:8]}}, lane_data_o);
        @(posedge sys_clk_i);
        #1;
      end
      for (p = 0; p < 8 && m < 6; p++)
        for (r = p + 1; r < 8; r++)
          chk("lane phase", 1, sig[p] !== sig[r]);
      $display("test pattern %0d done", m);
    end
    wr(8'h00, 32'h60);
    repeat (4) @(posedge sys_clk_i);
    #1;
    chk("no bypass", 0, link_bypass_o);
    wr(8'h00, 32'h63);
    repeat (10) @(posedge sys_clk_i);
    #1;
    chk("mode down drivers", 0, lane_drv_en_o);
    rd(8'h04, d);
    chk("mode down run", 0, d[0]);
    $display("test power done");
    results();
  end
endmodule // tb_serial_lane_map_test_power

// [include/slm_cfg.svh]
// Register offsets, field positions, reset values and pattern constants of the lane mapper.
`ifndef SLM_CFG_SVH
`define SLM_CFG_SVH
`define SLM_CTRL_ADDR  8'h00
`define SLM_STAT_ADDR  8'h04
`define SLM_MAP_LO     0
`define SLM_MAP_HI     1
`define SLM_FOUR_BIT   2
`define SLM_ALT_BIT    3
`define SLM_FEC_BIT    4
`define SLM_PAIR_LO    5
`define SLM_PAIR_HI    6
`define SLM_TEST_LO    8
`define SLM_TEST_HI    10
`define SLM_STAT_RUN   0
`define SLM_STAT_PD    1
`define SLM_STAT_DRV_LO 8
`define SLM_STAT_DRV_HI 15
`define SLM_PAIR_RST   2'h3
`define SLM_LANES      8
`define SLM_W10        5'd10
`define SLM_W12        5'd12
`define SLM_OCT_BITS   5'd8
`define SLM_CLK_HI     8'hff
`define SLM_CLK_LO     8'h00
`define SLM_P7_A       6
`define SLM_P7_B       7
`define SLM_P9_A       5
`define SLM_P9_B       9
`define SLM_P15_A      14
`define SLM_P15_B      15
`define SLM_P23_A      18
`define SLM_P23_B      23
`define SLM_P31_A      28
`define SLM_P31_B      31
`endif

// [include/slm_pkg.sv]
// Types shared by the lane mapper modules.
package slm_pkg;
  typedef enum logic [1:0] {
    SLM_MAP10_DUAL,
    SLM_MAP12_QUAD,
    SLM_MAP12_DUAL,
    SLM_MAP_OFF
  } slm_map_t;
  typedef enum logic [2:0] {
    SLM_T_NONE,
    SLM_T_PRBS7,
    SLM_T_PRBS9,
    SLM_T_PRBS15,
    SLM_T_PRBS23,
    SLM_T_PRBS31,
    SLM_T_CLK
  } slm_test_t;
  typedef enum logic [1:0] {
    SLM_S_DOWN,
    SLM_S_WAKE,
    SLM_S_RUN
  } slm_state_t;
endpackage

// [logic/slm_pack.sv]
// Bit packer that turns a stream of 10- or 12-bit samples into lane octets.
`timescale 1ns/100ps
`include "slm_cfg.svh"
module slm_pack
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        clr_i,
  input  wire logic        stb_i,
  input  wire logic        wide_i,
  input  wire logic [11:0] smp_i,
  output logic      [7:0]  oct_o,
  output logic             oct_vld_o
);
  logic [23:0] acc;
  logic [23:0] next_acc;
  logic [4:0]  cnt;
  logic [4:0]  next_cnt;
  logic [7:0]  next_oct;
  logic        next_vld;

  // At most one sample every other cycle keeps the backlog below 20 bits.
  always_comb
  begin
    logic [4:0]  sum;
    logic [23:0] a;
    sum = cnt;
    a = acc;
    if (stb_i)
    begin
      if (wide_i)
      begin
        a = {acc[11:0], smp_i};
        sum = cnt + `SLM_W12;
      end
      else
      begin
        a = {acc[13:0], smp_i[11:2]};
        sum = cnt + `SLM_W10;
      end
    end
    next_acc = a;
    next_cnt = sum;
    next_oct = oct_o;
    next_vld = 1'b0;
    if (sum >= `SLM_OCT_BITS)
    begin
      next_oct = 8'(a >> (sum - `SLM_OCT_BITS));
      next_cnt = sum - `SLM_OCT_BITS;
      next_vld = 1'b1;
    end
    if (clr_i)
    begin
      next_cnt = 5'h00;
      next_vld = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      acc       <= 24'h000000;
      cnt       <= 5'h00;
      oct_o     <= 8'h00;
      oct_vld_o <= 1'b0;
    end
    else
    begin
      acc       <= next_acc;
      cnt       <= next_cnt;
      oct_o     <= next_oct;
      oct_vld_o <= next_vld;
    end
  end
endmodule // slm_pack

// [logic/slm_prbs.sv]
// Per-lane pseudo-random generator producing eight bits per clock.
`timescale 1ns/100ps
`include "slm_cfg.svh"
module slm_prbs
  import slm_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        load_i,
  input  wire logic        run_i,
  input  wire slm_test_t   sel_i,
  input  wire logic [30:0] seed_i,
  output logic      [7:0]  oct_o
);
  logic [30:0] sr;
  logic [30:0] next_sr;
  logic [7:0]  next_oct;

  // Shift register bit j holds the bit sent j+1 positions ago.
  always_comb
  begin
    int ta;
    int tb;
    ta = `SLM_P7_A;
    tb = `SLM_P7_B;
    next_sr = sr;
    next_oct = oct_o;
    case (sel_i)
      SLM_T_PRBS9:
      begin
        ta = `SLM_P9_A;
        tb = `SLM_P9_B;
      end
      SLM_T_PRBS15:
      begin
        ta = `SLM_P15_A;
        tb = `SLM_P15_B;
      end
      SLM_T_PRBS23:
      begin
        ta = `SLM_P23_A;
        tb = `SLM_P23_B;
      end
      SLM_T_PRBS31:
      begin
        ta = `SLM_P31_A;
        tb = `SLM_P31_B;
      end
      default:
      begin
        ta = `SLM_P7_A;
        tb = `SLM_P7_B;
      end
    endcase
    if (load_i)
      next_sr = seed_i;
    else if (run_i)
    begin
      for (int k = 0; k < 8; k++)
      begin
        next_sr = {next_sr[29:0], next_sr[ta-1] ^ next_sr[tb-1]};
        next_oct = {next_oct[6:0], next_sr[0]};
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sr    <= 31'h00000001;
      oct_o <= 8'h00;
    end
    else
    begin
      sr    <= next_sr;
      oct_o <= next_oct;
    end
  end
endmodule // slm_prbs

// [logic/slm_top.sv]
// Sample-to-lane mapping, power-down control and serializer test patterns.
`timescale 1ns/100ps
`include "slm_cfg.svh"
module slm_top
  import slm_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wr_data_i,
  input  wire logic        wr_en_i,
  input  wire logic        rd_en_i,
  output logic      [31:0] rd_data_o,
  input  wire logic        power_down_pin_i,
  input  wire logic        smp_valid_i,
  input  wire logic [11:0] smp_a_i,
  input  wire logic [11:0] smp_b_i,
  input  wire logic [11:0] smp_c_i,
  input  wire logic [11:0] smp_d_i,
  output logic      [63:0] lane_data_o,
  output logic      [7:0]  lane_valid_o,
  output logic      [7:0]  lane_drv_en_o,
  output logic             link_bypass_o,
  output logic             sync_hdr_fec_o
);
  // Channel carried by a logical lane in the given map.
  function automatic logic [1:0] lane_chan(input slm_map_t m, input logic [2:0] l);
    if (m == SLM_MAP12_QUAD)
      lane_chan = l[2:1];
    else
      lane_chan = {1'b0, l[2]};
  endfunction

  slm_map_t   lane_map_mode;
  slm_map_t   next_map;
  slm_test_t  serializer_test_select;
  slm_test_t  next_test;
  logic       four_lane;
  logic       next_four;
  logic       alternate_lane_select;
  logic       next_alt;
  logic       fec;
  logic       next_fec;
  logic [1:0] channel_pair_enable;
  logic [1:0] next_pair;
  logic [31:0] ctrl_word;
  logic [31:0] next_rd;
  logic       ctrl_wr;

  assign ctrl_wr = wr_en_i && (addr_i == `SLM_CTRL_ADDR);

  // Register file; power-down never touches it, so settings survive.
  always_comb
  begin
    next_map  = lane_map_mode;
    next_test = serializer_test_select;
    next_four = four_lane;
    next_alt  = alternate_lane_select;
    next_fec  = fec;
    next_pair = channel_pair_enable;
    if (ctrl_wr)
    begin
      next_map  = slm_map_t'(wr_data_i[`SLM_MAP_HI:`SLM_MAP_LO]);
      next_four = wr_data_i[`SLM_FOUR_BIT];
      next_alt  = wr_data_i[`SLM_ALT_BIT];
      next_fec  = wr_data_i[`SLM_FEC_BIT];
      next_pair = wr_data_i[`SLM_PAIR_HI:`SLM_PAIR_LO];
      next_test = slm_test_t'(wr_data_i[`SLM_TEST_HI:`SLM_TEST_LO]);
      if (wr_data_i[`SLM_TEST_HI:`SLM_TEST_LO] > 3'(SLM_T_CLK))
        next_test = SLM_T_NONE;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      lane_map_mode          <= SLM_MAP10_DUAL;
      serializer_test_select <= SLM_T_NONE;
      four_lane              <= 1'b0;
      alternate_lane_select  <= 1'b0;
      fec                    <= 1'b0;
      channel_pair_enable    <= `SLM_PAIR_RST;
    end
    else
    begin
      lane_map_mode          <= next_map;
      serializer_test_select <= next_test;
      four_lane              <= next_four;
      alternate_lane_select  <= next_alt;
      fec                    <= next_fec;
      channel_pair_enable    <= next_pair;
    end
  end

  assign sync_hdr_fec_o = fec;

  // Pin synchroniser; the first stage feeds the second only.
  logic pd_meta;
  logic pd_sync;
  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pd_meta <= 1'b0;
      pd_sync <= 1'b0;
    end
    else
    begin
      pd_meta <= power_down_pin_i;
      pd_sync <= pd_meta;
    end
  end

  slm_state_t state;
  slm_state_t next_state;
  logic       powered;
  logic       running;

  assign powered = !pd_sync && (lane_map_mode != SLM_MAP_OFF);
  assign running = (state == SLM_S_RUN);

  always_comb
  begin
    case (state)
      SLM_S_DOWN:
        next_state = powered ? SLM_S_WAKE : SLM_S_DOWN;
      SLM_S_WAKE:
        next_state = powered ? SLM_S_RUN : SLM_S_DOWN;
      SLM_S_RUN:
        next_state = powered ? SLM_S_RUN : SLM_S_DOWN;
      default:
        next_state = SLM_S_DOWN;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      state <= SLM_S_DOWN;
    else
      state <= next_state;
  end

  // Round-robin counter shared by all channels, which sample together.
  logic [1:0] rr;
  logic [1:0] next_rr;
  logic       clk_ph;
  logic       next_clk_ph;
  always_comb
  begin
    next_rr = rr;
    if (!running)
      next_rr = 2'h0;
    else if (smp_valid_i)
      next_rr = rr + 2'h1;
    next_clk_ph = running && (serializer_test_select == SLM_T_CLK) && !clk_ph;
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rr     <= 2'h0;
      clk_ph <= 1'b0;
    end
    else
    begin
      rr     <= next_rr;
      clk_ph <= next_clk_ph;
    end
  end

  logic [11:0] smp [4];
  logic [7:0]  use_l;
  logic [7:0]  stb_l;
  logic        normal;
  logic        swap;
  logic [7:0]  pk_oct [`SLM_LANES];
  logic [7:0]  pk_vld;
  logic [7:0]  pr_oct [`SLM_LANES];

  assign normal = running && (serializer_test_select == SLM_T_NONE);
  assign swap   = four_lane && alternate_lane_select;

  always_comb
  begin
    logic [1:0] ch;
    ch = 2'h0;
    smp[0] = smp_a_i;
    smp[1] = smp_b_i;
    smp[2] = smp_c_i;
    smp[3] = smp_d_i;
    use_l = 8'h00;
    stb_l = 8'h00;
    for (int l = 0; l < `SLM_LANES; l++)
    begin
      ch = lane_chan(lane_map_mode, 3'(l));
      use_l[l] = channel_pair_enable[ch[1]] && (lane_map_mode != SLM_MAP_OFF);
      if (four_lane && l >= 4)
        use_l[l] = 1'b0;
      if (lane_map_mode == SLM_MAP12_QUAD)
        stb_l[l] = (l[0] == rr[0]);
      else
        stb_l[l] = (l[1:0] == rr);
      stb_l[l] = stb_l[l] && smp_valid_i && use_l[l] && normal;
    end
  end

  genvar g;
  generate
    for (g = 0; g < `SLM_LANES; g++)
    begin : g_lane
      slm_pack u_pack
      (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .clr_i     (!normal),
        .stb_i     (stb_l[g]),
        .wide_i    (lane_map_mode != SLM_MAP10_DUAL),
        .smp_i     (smp[lane_chan(lane_map_mode, 3'(g))]),
        .oct_o     (pk_oct[g]),
        .oct_vld_o (pk_vld[g])
      );
      // Seeds differ per lane and are non-zero in every register length.
      slm_prbs u_prbs
      (
        .sys_clk_i (sys_clk_i),
        .rst_b_i   (rst_b_i),
        .load_i    ((state == SLM_S_WAKE) || ctrl_wr),
        .run_i     (running),
        .sel_i     (serializer_test_select),
        .seed_i    (31'(g + 1)),
        .oct_o     (pr_oct[g])
      );
    end
  endgenerate

  // Output stage; test patterns skip the packers entirely.
  logic [63:0] next_data;
  logic [7:0]  next_lvld;
  logic [7:0]  next_drv;
  always_comb
  begin
    int src;
    src = 0;
    next_data = 64'h0;
    next_lvld = 8'h00;
    next_drv  = 8'h00;
    for (int p = 0; p < `SLM_LANES; p++)
    begin
      src = swap ? p - 4 : p;
      if (swap && p < 4)
        next_drv[p] = 1'b0;
      else if (running && src >= 0)
        next_drv[p] = use_l[src];
      if (next_drv[p])
      begin
        case (serializer_test_select)
          SLM_T_NONE:
          begin
            next_data[p*8 +: 8] = pk_oct[src];
            next_lvld[p] = pk_vld[src];
          end
          SLM_T_CLK:
          begin
            next_data[p*8 +: 8] = clk_ph ? `SLM_CLK_LO : `SLM_CLK_HI;
            next_lvld[p] = 1'b1;
          end
          default:
          begin
            next_data[p*8 +: 8] = pr_oct[src];
            next_lvld[p] = 1'b1;
          end
        endcase
      end
    end
  end

  always_comb
  begin
    ctrl_word = 32'h0;
    ctrl_word[`SLM_MAP_HI:`SLM_MAP_LO]   = lane_map_mode;
    ctrl_word[`SLM_FOUR_BIT]             = four_lane;
    ctrl_word[`SLM_ALT_BIT]              = alternate_lane_select;
    ctrl_word[`SLM_FEC_BIT]              = fec;
    ctrl_word[`SLM_PAIR_HI:`SLM_PAIR_LO] = channel_pair_enable;
    ctrl_word[`SLM_TEST_HI:`SLM_TEST_LO] = serializer_test_select;
    next_rd = 32'h0;
    if (rd_en_i && addr_i == `SLM_CTRL_ADDR)
      next_rd = ctrl_word;
    else if (rd_en_i && addr_i == `SLM_STAT_ADDR)
    begin
      next_rd[`SLM_STAT_RUN] = running;
      next_rd[`SLM_STAT_PD]  = pd_sync;
      next_rd[`SLM_STAT_DRV_HI:`SLM_STAT_DRV_LO] = lane_drv_en_o;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      lane_data_o   <= 64'h0;
      lane_valid_o  <= 8'h00;
      lane_drv_en_o <= 8'h00;
      link_bypass_o <= 1'b0;
      rd_data_o     <= 32'h0;
    end
    else
    begin
      lane_data_o   <= next_data;
      lane_valid_o  <= next_lvld;
      lane_drv_en_o <= next_drv;
      link_bypass_o <= (serializer_test_select != SLM_T_NONE);
      rd_data_o     <= next_rd;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  chk_pd_drivers: assert property (pd_sync |-> ##2 lane_drv_en_o == 8'h00)
    else $error("Drivers still enabled during power-down.");
  chk_sets_exclusive: assert property ((four_lane ##1 four_lane) |->
    !(|lane_drv_en_o[3:0] && |lane_drv_en_o[7:4]))
    else $error("Default and alternate lanes active together.");
  chk_alt_route: assert property (swap |=> lane_drv_en_o[3:0] == 4'h0)
    else $error("Default lanes driven while alternate selected.");
  chk_pair_off: assert property (channel_pair_enable == 2'h0 |=> lane_drv_en_o == 8'h00)
    else $error("Lanes driven with all channel pairs off.");
  chk_regs_kept: assert property (!wr_en_i |=> $stable(ctrl_word))
    else $error("Configuration changed without a write.");
  chk_fec_select: assert property (ctrl_wr |=> sync_hdr_fec_o == $past(wr_data_i[`SLM_FEC_BIT]))
    else $error("Sync header choice not taken from write.");
  chk_bypass_flag: assert property ((serializer_test_select == SLM_T_NONE) |=> !link_bypass_o)
    else $error("Bypass set with no test selected.");
  chk_clock_toggle: assert property (((serializer_test_select == SLM_T_CLK) && running)[*3]
    ##0 (lane_drv_en_o[0] && $past(lane_drv_en_o[0]))
    |-> lane_data_o[7:0] == ~$past(lane_data_o[7:0]))
    else $error("Clock pattern did not alternate octets.");
  chk_prbs7_taps: assert property (((serializer_test_select == SLM_T_PRBS7) && running
    && !wr_en_i)[*4] ##0 (lane_valid_o[0] && $past(lane_valid_o[0]))
    |-> lane_data_o[7] == ($past(lane_data_o[5]) ^ $past(lane_data_o[6])))
    else $error("PRBS7 recursion broken on lane 0.");
endmodule // slm_top
